// ---- src/bbp_exec.sv ----
`timescale 1ns/1ps
// Operation
// - branch-if-bit-set loads target into pc when bit is one, else falls through.
// - pc advances by 3, then signed third byte is added for target.
// - branch-if-bit-set never writes the bit nor any flag.
// - branch-and-clear with bit one branches and writes zero to the bit.
// - branch-and-clear with bit zero does no write and falls through.
// - branch-and-clear reads output latch, not the pin level.
// - branch-and-clear changes no flags; only side effect is the clear.
// - pointer increment carries low byte wrap into high byte.
// - pointer increment wraps modulo 2^16 and leaves flags alone.
module bbp_exec (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              start_in,
  input  wire bbp_pkg::bbp_req_t req_in,
  input  wire logic              bit_rdata_in,
  output logic                   bit_rd_out,
  output logic                   bit_wr_out,
  output logic                   bit_latch_sel_out,
  output logic             [7:0] bit_addr_out,
  output logic                   bit_wdata_out,
  output logic                   pc_load_out,
  output logic            [15:0] pc_out,
  output logic                   dp_load_out,
  output logic            [15:0] data_pointer_out,
  output logic                   busy_out,
  output logic                   done_out
);
  import bbp_pkg::*;

  // sequencer: idle, then read (bit on the port), then resolve (clear on the port), then idle (done);
  // an increment never leaves idle, so increments may run one per cycle;
  // a branch holds the sequencer for its two cycles and refuses new starts
  typedef enum logic [1:0] {
    BBP_IDLE,
    BBP_READ,
    BBP_RESOLVE
  } bbp_state_t;

  // sequencer state and the captured request
  bbp_state_t  state_q, state_d;
  bbp_req_t    req_q;
  // bit port and result registers
  logic [15:0] data_pointer_q;
  bbp_bit_t    bit_q, bit_d;
  logic        pc_load_q, dp_load_q, done_q, busy_q;
  logic [15:0] pc_q;

  // incremented pointer
  logic [15:0] dp_next;
  bbp_dp_inc u_inc (
    .dp_in  (data_pointer_q),
    .dp_out (dp_next)
  );

  // sequential address and relative target
  wire logic [15:0] seq_pc    = req_q.pc + BBP_LEN_BRANCH;
  // displacement byte is signed: sign-extend before the add
  wire logic [15:0] rel_ext   = {{8{req_q.rel[BBP_SIGN_POS]}}, req_q.rel};
  wire logic [15:0] target_pc = seq_pc + rel_ext;
  wire logic        is_clr    = (req_q.op == BBP_OP_BRANCH_CLR);
  wire logic        taken     = bit_rdata_in;
  // branch-and-clear must see the latch so a pin held low can't mask a set bit
  wire logic        want_latch = (req_in.op == BBP_OP_BRANCH_CLR);
  // start is only heard while idle; a start that arrives during a branch is dropped
  wire logic        accept    = start_in && (state_q == BBP_IDLE);
  wire logic        is_branch = (req_in.op == BBP_OP_BRANCH_SET) || want_latch;
  wire logic        is_inc    = (req_in.op == BBP_OP_INC_DP);

  // accepted request, split by kind
  wire logic        do_inc     = accept && is_inc;
  wire logic        do_branch  = accept && is_branch;
  // sequencer phases
  wire logic        in_read    = (state_q == BBP_READ);
  wire logic        in_resolve = (state_q == BBP_RESOLVE);
  // clear only a bit that read one; a zero bit sees no write at all
  wire logic        clear_now  = in_read && is_clr && taken;
  // pc chosen in the read cycle, while the bit value is still on the port
  wire logic [15:0] branch_pc  = taken ? target_pc : seq_pc;
  // increment is one byte long, so pc moves on by one
  wire logic [15:0] inc_pc     = req_in.pc + BBP_LEN_INC;

  // next state: branches take two cycles, increment completes at once
  always_comb begin
    state_d = state_q;
    case (state_q)
      BBP_IDLE: begin
        // increment completes here without leaving idle
        if (do_branch) begin
          state_d = BBP_READ;
        end
      end
      BBP_READ: begin
        state_d = BBP_RESOLVE;
      end
      BBP_RESOLVE: begin
        state_d = BBP_IDLE;
      end
      default: begin
        // unused encoding falls back to idle
        state_d = BBP_IDLE;
      end
    endcase
  end

  // bit port drive: read in first cycle, conditional clear in second
  always_comb begin
    bit_d = '0;
    bit_d.addr = bit_q.addr;
    bit_d.latch_sel = bit_q.latch_sel;
    // address and source captured with the read strobe
    if (do_branch) begin
      bit_d.rd = 1'h1;
      bit_d.addr = req_in.bit_addr;
      bit_d.latch_sel = want_latch;
    end else if (clear_now) begin
      bit_d.wr = 1'h1;
      bit_d.wdata = 1'h0;
    end
    // plain branch and zero-bit clear never write
  end

  // state register; a sync reset lands the sequencer in idle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= BBP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // request held from acceptance so decode may move on to the next fetch
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      req_q <= '0;
    end else if (accept) begin
      req_q <= req_in;
    end
  end

  // bit port registers: every bit-side output leaves a flop
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_q <= '0;
    end else begin
      bit_q <= bit_d;
    end
  end

  // pc result: one byte on for increment, branch outcome in the read cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_q <= BBP_PC_RESET;
    end else if (do_inc) begin
      pc_q <= inc_pc;
    end else if (in_read) begin
      pc_q <= branch_pc;
    end
  end

  // pc strobe for the increment and for every branch outcome
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pc_load_q <= 1'h0;
    end else begin
      pc_load_q <= do_inc || in_read;
    end
  end

  // data pointer: stepped by one on each accepted increment
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_pointer_q <= BBP_DP_RESET;
    end else if (do_inc) begin
      data_pointer_q <= dp_next;
    end
  end

  // pointer strobe; no flag outputs exist, so no flag can move
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dp_load_q <= 1'h0;
    end else begin
      dp_load_q <= do_inc;
    end
  end

  // busy mirrors the next state so a second start is refused in flight
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_q <= 1'h0;
    end else begin
      busy_q <= (state_d != BBP_IDLE);
    end
  end

  // done: at once for increment, after the resolve cycle for branches
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_q <= 1'h0;
    end else begin
      done_q <= do_inc || in_resolve;
    end
  end

  // bit port outputs straight from the port register
  assign bit_rd_out        = bit_q.rd;
  assign bit_wr_out        = bit_q.wr;
  assign bit_latch_sel_out = bit_q.latch_sel;
  assign bit_addr_out      = bit_q.addr;
  assign bit_wdata_out     = bit_q.wdata;

  // result outputs straight from their flops
  assign pc_load_out       = pc_load_q;
  assign pc_out            = pc_q;
  assign dp_load_out       = dp_load_q;
  assign data_pointer_out  = data_pointer_q;
  assign busy_out          = busy_q;
  assign done_out          = done_q;
endmodule

// ---- src/bbp_pkg.sv ----
package bbp_pkg;

  // operation select from the decoder
  typedef enum logic [1:0] {
    BBP_OP_NONE,
    BBP_OP_INC_DP,
    BBP_OP_BRANCH_SET,
    BBP_OP_BRANCH_CLR
  } bbp_op_t;

  // request from fetch/decode
  typedef struct packed {
    bbp_op_t    op;
    logic [7:0] bit_addr;
    logic [7:0] rel;
    logic [15:0] pc;
  } bbp_req_t;

  // bit storage access
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       latch_sel;
    logic [7:0] addr;
    logic       wdata;
  } bbp_bit_t;

  localparam logic [15:0] BBP_LEN_INC     = 16'h0001;
  localparam logic [15:0] BBP_LEN_BRANCH  = 16'h0003;
  localparam logic [15:0] BBP_DP_RESET    = 16'h0000;
  localparam logic [15:0] BBP_PC_RESET    = 16'h0000;
  localparam logic [7:0]  BBP_ADDR_RESET  = 8'h00;
  localparam int          BBP_BIT_BYTE    = 7;
  localparam int          BBP_SIGN_POS    = 7;

endpackage

// ---- src/bbp_dp_inc.sv ----
`timescale 1ns/1ps
// 16-bit pointer incrementer, no flags produced
module bbp_dp_inc (
  input  wire logic [15:0] dp_in,
  output logic      [15:0] dp_out
);
  import bbp_pkg::*;

  // low byte carry ripples into high byte
  wire logic [7:0] low_next = dp_in[7:0] + 8'h01;
  wire logic       low_wrap = (dp_in[7:0] == 8'hFF);
  wire logic [7:0] high_next = dp_in[15:8] + {7'h00, low_wrap};

  // top carry is dropped: wraps modulo 2^16
  assign dp_out = {high_next, low_next};
endmodule

// ---- test/bbp_exec_chk.sv ----
`timescale 1ns/1ps
// req_in is held by the driver until done, so targets come from it directly
module bbp_exec_chk import bbp_pkg::*; (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              start_in,
  input wire bbp_pkg::bbp_req_t req_in,
  input wire logic              bit_rdata_in,
  input wire logic              bit_rd_out,
  input wire logic              bit_wr_out,
  input wire logic              bit_latch_sel_out,
  input wire logic [7:0]        bit_addr_out,
  input wire logic              bit_wdata_out,
  input wire logic              pc_load_out,
  input wire logic [15:0]       pc_out,
  input wire logic              dp_load_out,
  input wire logic [15:0]       data_pointer_out,
  input wire logic              busy_out,
  input wire logic              done_out
);
  // fall-through and taken addresses
  wire [15:0] nxt = req_in.pc + 16'h0003;
  wire [15:0] tgt = nxt + {{8{req_in.rel[7]}}, req_in.rel};
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  sequence op_s(bbp_op_t o); start_in && !busy_out && req_in.op == o; endsequence
  sequence br_s; start_in && !busy_out && req_in.op[1]; endsequence
  sequence clr_s; op_s(BBP_OP_BRANCH_CLR) ##1 bit_rd_out; endsequence
  inc_step_a: assert property (op_s(BBP_OP_INC_DP) |=> dp_load_out && done_out
    && data_pointer_out == $past(data_pointer_out) + 16'h0001) else $error("pointer step wrong");
  inc_pc_a: assert property (op_s(BBP_OP_INC_DP) |=> pc_load_out
    && pc_out == $past(req_in.pc) + 16'h0001) else $error("increment pc wrong");
  br_read_a: assert property (br_s |=> bit_rd_out && busy_out) else $error("no bit read");
  br_addr_a: assert property (br_s |=> bit_addr_out == $past(req_in.bit_addr))
    else $error("bit address wrong");
  br_taken_a: assert property (br_s ##1 bit_rdata_in |=> pc_load_out && pc_out == tgt)
    else $error("taken target wrong");
  br_fall_a: assert property (br_s ##1 !bit_rdata_in |=> pc_load_out && pc_out == nxt)
    else $error("fall through wrong");
  set_keep_a: assert property (op_s(BBP_OP_BRANCH_SET) |=> !bit_wr_out [*3])
    else $error("bit written");
  clr_write_a: assert property (clr_s ##0 bit_rdata_in |=> bit_wr_out && !bit_wdata_out)
    else $error("no clear");
  clr_keep_a: assert property (clr_s ##0 !bit_rdata_in |=> !bit_wr_out) else $error("zero bit written");
  latch_sel_a: assert property (op_s(BBP_OP_BRANCH_CLR) |=> bit_latch_sel_out) else $error("pin read");
  br_done_a: assert property (br_s |=> ##2 done_out && !busy_out) else $error("branch length wrong");
endmodule
bind bbp_exec bbp_exec_chk u_chk (.*);

// ---- test/bbp_exec_test.sv ----
`timescale 1ns/1ps
// drives the executor directly at falling edges and judges each instruction
module bbp_exec_test;
  import bbp_pkg::*;
  logic        clk_in, rst_in, start_in, bit_rdata_in, bit_rd_out, bit_wr_out, bit_latch_sel_out;
  logic        bit_wdata_out, pc_load_out, dp_load_out, busy_out, done_out;
  logic [7:0]  bit_addr_out;
  logic [15:0] pc_out, data_pointer_out;
  bbp_req_t    req_in;
  int          failures = 0;
  int          n_checks = 0;
  bbp_exec DUT (
    .clk_in            (clk_in),
    .rst_in            (rst_in),
    .start_in          (start_in),
    .req_in            (req_in),
    .bit_rdata_in      (bit_rdata_in),
    .bit_rd_out        (bit_rd_out),
    .bit_wr_out        (bit_wr_out),
    .bit_latch_sel_out (bit_latch_sel_out),
    .bit_addr_out      (bit_addr_out),
    .bit_wdata_out     (bit_wdata_out),
    .pc_load_out       (pc_load_out),
    .pc_out            (pc_out),
    .dp_load_out       (dp_load_out),
    .data_pointer_out  (data_pointer_out),
    .busy_out          (busy_out),
    .done_out          (done_out)
  );
  // 20 ns core clock
  initial begin
    clk_in = 0;
    forever #10 clk_in = ~clk_in;
  end
  task automatic chk(input logic c);
    n_checks++;
    if (c !== 1'h1) begin
      failures++;
      $display("[FAIL] %0t ns: unexpected output", $time);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // one branch; bit value held for the whole op since it is only sampled on the read
  task automatic br(input bbp_op_t o, input logic b, input logic [7:0] r, input logic [15:0] e);
    req_in = '{o, 8'h2A, r, 16'h1000};
    bit_rdata_in = b;
    start_in = 1;
    @(negedge clk_in) start_in = 0;
    chk(bit_rd_out && bit_addr_out === 8'h2A && bit_latch_sel_out === (o == BBP_OP_BRANCH_CLR));
    @(negedge clk_in);
    chk(pc_load_out && pc_out === e && dp_load_out === 1'h0);
    chk(bit_wr_out === (b && o == BBP_OP_BRANCH_CLR) && bit_wdata_out === 1'h0);
    @(negedge clk_in);
    chk(done_out === 1'h1 && busy_out === 1'h0 && bit_wr_out === 1'h0);
  endtask
  // one increment, then a mid-run reset must clear pointer and results
  task automatic t_rst;
    req_in = '{BBP_OP_INC_DP, 8'h00, 8'h00, 16'h0300};
    start_in = 1;
    @(negedge clk_in) start_in = 0;
    chk(data_pointer_out === 16'h0001 && pc_out === 16'h0301);
    rst_in = 1;
    @(negedge clk_in) rst_in = 0;
    chk(data_pointer_out === 16'h0000 && pc_out === 16'h0000 && !pc_load_out && !done_out && !busy_out);
  endtask
  // backward taken, forward not taken
  task automatic t_jb;
    br(BBP_OP_BRANCH_SET, 1'h1, 8'h80, 16'h0F83);
    br(BBP_OP_BRANCH_SET, 1'h0, 8'h7F, 16'h1003);
  endtask
  // set bit clears and branches, clear bit is left alone
  task automatic t_jbc;
    br(BBP_OP_BRANCH_CLR, 1'h1, 8'h7F, 16'h1082);
    br(BBP_OP_BRANCH_CLR, 1'h0, 8'h10, 16'h1003);
  endtask
  // full sweep back to back: every low byte carry and the final wrap
  task automatic t_inc;
    req_in = '{BBP_OP_INC_DP, 8'h00, 8'h00, 16'h0200};
    start_in = 1;
    for (int i = 1; i <= 65536; i++) begin
      @(negedge clk_in);
      chk(dp_load_out && data_pointer_out === 16'(i));
    end
    start_in = 0;
    chk(pc_out === 16'h0201 && done_out === 1'h1);
  endtask
  // reset for 10 cycles, then the scenarios
  initial begin
    rst_in = 1;
    start_in = 0;
    bit_rdata_in = 0;
    req_in = '0;
    repeat (10) @(negedge clk_in);
    rst_in = 0;
    t_jb;
    t_jbc;
    t_rst;
    t_inc;
    conclude;
  end
  // the sweep needs about 1.31 ms; allow some margin
  initial begin
    #1_500_000;
    failures++;
    conclude;
  end
endmodule
